/* File: design/pss_defines.svh */
// Constants for the panel supply sequencer and fault supervisor.
// Notes on behaviour
// - Regulator on enable, bias after regulator good.
// - Step-down starts once bias within window.
// - Bias out of window drops all but regulator and bias, reruns.
// - Step-down good starts first delay, negative pump.
// - Secondary enable ignored until step-down good.
// - Secondary enable: inrush switch first, then step-up.
// - Step-up good runs second delay, positive pump.
// - Modulator needs slice enable and positive pump good.
// - Frequency select picks rate; pumps at half.
// - No start-up while input below lockout.
// - Primary enable low stops everything, regulator too.
// - Secondary low stops step-up, positive pump, modulator.
// - Hot or brown-out: all off but regulator.
// - Ramps past 2V arm their blocks' fault checks.
// - Persistent armed fault sets latch, all off.
// - Latch clears when regulator collapses; auto restart.
// - Fault thresholds per rail, negative pump differs.
// - Modulator fault: two missed pull-ups in row.
// - Amplifier thermal shutdown only with primary enable.
// - Slice enable low: mux off, output grounded.
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH

// Reference clock rate in hertz.
`define PSS_REF_CLK_HZ 100000000
// Low and high switching rates in hertz.
`define PSS_FOSC_LO_HZ 650000
`define PSS_FOSC_HI_HZ 1300000
// Reference clock cycles per switching period, rounded down.
`define PSS_OSC_DIV_LO (`PSS_REF_CLK_HZ / `PSS_FOSC_LO_HZ)
`define PSS_OSC_DIV_HI (`PSS_REF_CLK_HZ / `PSS_FOSC_HI_HZ)
// Width of the switching divider counter.
`define PSS_OSC_CNT_W 8

// Fault persistence interval in microseconds.
`define PSS_FAULT_US 63
// Persistence interval in switching periods, rounded up.
`define PSS_FAULT_OSC_LO ((`PSS_FAULT_US * `PSS_FOSC_LO_HZ + 999999) / 1000000)
`define PSS_FAULT_OSC_HI ((`PSS_FAULT_US * `PSS_FOSC_HI_HZ + 999999) / 1000000)
// Width of each persistence counter.
`define PSS_FAULT_CNT_W 7

// Consecutive missed pull-ups that count as a modulator fault.
`define PSS_GPM_MISS_LIMIT 2

// Number of sense inputs and of fault-checked blocks.
`define PSS_SENSE_W 24
`define PSS_NUM_BLOCKS 6
// Block positions in the fault and arm vectors.
`define PSS_BLK_BUCK 0
`define PSS_BLK_NEG 1
`define PSS_BLK_BOOST 2
`define PSS_BLK_SWITCH 3
`define PSS_BLK_POS 4
`define PSS_BLK_GPM 5

`endif

/* File: design/pss_pkg.sv */
// Types shared by the panel supply sequencer files.
`include "pss_defines.svh"

package pss_pkg;

  // Sequencer states.
  typedef enum logic [2:0] {
    st_off,
    st_reg_start,
    st_bias_charge,
    st_run,
    st_thermal_hold,
    st_fault
  } pss_state_t;

  // Synchronised digital indications from pins and analog comparators.
  typedef struct packed {
    logic primary_enable;
    logic secondary_enable;
    logic slice_enable_input;
    logic frequency_select;
    logic vin_above_lower_uvlo;
    logic vin_above_upper_uvlo;
    logic temp_over_trip;
    logic temp_below_release;
    logic regulator_above_uvlo;
    logic bias_in_window;
    logic buck_above_90;
    logic buck_ramp_above_2v;
    logic delay1_ramp_at_threshold;
    logic delay1_cap_absent;
    logic delay1_ramp_above_2v;
    logic neg_feedback_high;
    logic switch_fault;
    logic boost_above_90;
    logic boost_ramp_above_2v;
    logic delay2_ramp_at_threshold;
    logic delay2_cap_absent;
    logic delay2_ramp_above_2v;
    logic pos_above_90;
    logic gate_high_reached;
  } pss_sense_t;

  // Enables sent to the analog blocks.
  typedef struct packed {
    logic regulator_en;
    logic bias_en;
    logic buck_en;
    logic delay1_ramp_en;
    logic neg_pump_en;
    logic switch_en;
    logic boost_en;
    logic delay2_ramp_en;
    logic pos_pump_en;
    logic gpm_en;
    logic slice_mux_en;
    logic gate_high_ground;
    logic amp_shutdown;
  } pss_enables_t;

  // Persistence timer state.
  typedef struct packed {
    logic [`PSS_FAULT_CNT_W-1:0] cnt;
    logic expired;
  } pss_timer_state_t;

  // Complete state of the sequencer.
  typedef struct packed {
    logic [`PSS_SENSE_W-1:0] s1;
    logic [`PSS_SENSE_W-1:0] s2;
    logic [`PSS_SENSE_W-1:0] s3;
    logic [`PSS_SENSE_W-1:0] stable;
    pss_state_t state;
    logic [`PSS_OSC_CNT_W-1:0] osc_cnt;
    logic osc_tick;
    logic pump_phase;
    logic pump_tick;
    logic [1:0] gpm_miss;
    logic buck_reached;
    logic neg_started;
    logic switch_on;
    logic pos_started;
    logic thermal_latch;
    logic fault_latch;
    pss_enables_t en;
  } pss_main_state_t;

endpackage

/* File: design/pss_fault_timer.sv */
// Fault persistence timer for one supervised block.
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_fault_timer
  import pss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic osc_tick,
  input wire logic armed,
  input wire logic fault,
  input wire logic [`PSS_FAULT_CNT_W-1:0] limit,
  output logic expired
);

  // Present and next timer state.
  pss_timer_state_t cur_reg;
  pss_timer_state_t cur_next;

  // Count switching periods while an armed fault stays present.
  always_comb begin
    cur_next = cur_reg;
    if (!(armed && fault)) begin
      // A fault that goes away early forgets its history.
      cur_next.cnt = '0;
      cur_next.expired = 1'b0;
    end else if (osc_tick && (cur_reg.cnt < limit)) begin
      // Counting whole oscillator periods keeps the interval rate-scaled.
      cur_next.cnt = cur_reg.cnt + 7'h01;
    end
    // Expiry is held while the fault stays, so the latch always sees it.
    cur_next.expired = armed && fault && (cur_next.cnt >= limit);
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Expiry output comes straight from the register.
  assign expired = cur_reg.expired;

  property p_restart_on_clear;
    @(posedge ref_clk) disable iff (!reset_n)
      !(armed && fault) |=> (cur_reg.cnt == 7'h00) && !expired;
  endproperty
  a_restart_on_clear: assert property (p_restart_on_clear)
    else $error("Persistence count did not restart after fault cleared.");

  property p_expire_at_limit;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(expired) |-> (cur_reg.cnt == limit) && $past(armed && fault);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit)
    else $error("Timer expired away from its persistence limit.");

endmodule

/* File: design/pss_sequencer.sv */
// Start-up sequencer and fault supervisor for a multi-rail panel supply.
`timescale 1ns/10ps
`include "pss_defines.svh"

module pss_sequencer
  import pss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input pss_sense_t sense,
  output pss_enables_t enables,
  output logic fault_latch,
  output logic osc_tick,
  output logic pump_tick
);

  // Present and next value of the whole state.
  pss_main_state_t cur_reg;
  pss_main_state_t cur_next;
  // Filtered view of the sense inputs.
  pss_sense_t sv;
  // Fault and arm indications, one bit per supervised block.
  logic [`PSS_NUM_BLOCKS-1:0] blk_fault;
  logic [`PSS_NUM_BLOCKS-1:0] blk_armed;
  logic [`PSS_NUM_BLOCKS-1:0] blk_expired;
  // Persistence interval for the selected rate.
  logic [`PSS_FAULT_CNT_W-1:0] fault_limit;
  // Last divider count of the selected switching period.
  logic [`PSS_OSC_CNT_W-1:0] div_last;
  // Modulator short-circuit indication.
  logic gpm_fault;
  // Any block has been faulty for the whole persistence interval.
  logic any_expired;
  // The next state keeps the rails of the running sequence.
  logic in_run;

  assign sv = pss_sense_t'(cur_reg.stable);

  // Rate selection shared by the divider and the persistence timers.
  assign div_last = sv.frequency_select ? 8'(`PSS_OSC_DIV_HI - 1) : 8'(`PSS_OSC_DIV_LO - 1);
  assign fault_limit = sv.frequency_select ? 7'(`PSS_FAULT_OSC_HI) : 7'(`PSS_FAULT_OSC_LO);

  // A modulator fault is two consecutive missed pull-ups.
  assign gpm_fault = (cur_reg.gpm_miss == 2'(`PSS_GPM_MISS_LIMIT));

  // Per-block fault thresholds from the comparators.
  assign blk_fault[`PSS_BLK_BUCK] = !sv.buck_above_90;
  assign blk_fault[`PSS_BLK_NEG] = sv.neg_feedback_high;
  assign blk_fault[`PSS_BLK_BOOST] = !sv.boost_above_90;
  assign blk_fault[`PSS_BLK_SWITCH] = sv.switch_fault;
  assign blk_fault[`PSS_BLK_POS] = !sv.pos_above_90;
  assign blk_fault[`PSS_BLK_GPM] = gpm_fault;

  // Each ramp past 2V arms only the blocks it belongs to.
  assign blk_armed[`PSS_BLK_BUCK] = cur_reg.en.buck_en && sv.buck_ramp_above_2v;
  assign blk_armed[`PSS_BLK_NEG] = cur_reg.en.neg_pump_en && sv.delay1_ramp_above_2v;
  assign blk_armed[`PSS_BLK_BOOST] = cur_reg.en.boost_en && sv.boost_ramp_above_2v;
  assign blk_armed[`PSS_BLK_SWITCH] = cur_reg.en.switch_en && sv.boost_ramp_above_2v;
  assign blk_armed[`PSS_BLK_POS] = cur_reg.en.pos_pump_en && sv.delay2_ramp_above_2v;
  assign blk_armed[`PSS_BLK_GPM] = cur_reg.en.gpm_en && sv.delay2_ramp_above_2v;

  // One persistence timer per supervised block.
  genvar gi;
  generate
    for (gi = 0; gi < `PSS_NUM_BLOCKS; gi++) begin : g_timer
      pss_fault_timer u_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .osc_tick(cur_reg.osc_tick),
        .armed(blk_armed[gi]),
        .fault(blk_fault[gi]),
        .limit(fault_limit),
        .expired(blk_expired[gi])
      );
    end
  endgenerate

  assign any_expired = |blk_expired;

  // Next-state logic for synchronisers, divider, sequence and enables.
  always_comb begin
    cur_next = cur_reg;
    in_run = 1'b0;

    // Three-stage synchroniser; a bit is taken once stages two and three agree.
    cur_next.s1 = sense;
    cur_next.s2 = cur_reg.s1;
    cur_next.s3 = cur_reg.s2;
    for (int i = 0; i < `PSS_SENSE_W; i++) begin
      if (cur_reg.s2[i] == cur_reg.s3[i]) begin
        cur_next.stable[i] = cur_reg.s3[i];
      end
    end

    // Switching divider; pumps get every second period.
    cur_next.osc_tick = 1'b0;
    cur_next.pump_tick = 1'b0;
    if (cur_reg.osc_cnt >= div_last) begin
      cur_next.osc_cnt = '0;
      cur_next.osc_tick = 1'b1;
      cur_next.pump_phase = !cur_reg.pump_phase;
      cur_next.pump_tick = cur_reg.pump_phase;
    end else begin
      cur_next.osc_cnt = cur_reg.osc_cnt + 8'h01;
    end

    // Missed pull-up counter, sampled once per switching period.
    if (!cur_reg.en.gpm_en) begin
      cur_next.gpm_miss = 2'h0;
    end else if (cur_reg.osc_tick) begin
      if (sv.gate_high_reached) begin
        cur_next.gpm_miss = 2'h0;
      end else if (!gpm_fault) begin
        cur_next.gpm_miss = cur_reg.gpm_miss + 2'h1;
      end
    end

    // Main sequence; the overrides below take priority over these steps.
    unique case (cur_reg.state)
      st_off: begin
        // Nothing starts while the input sits below lockout.
        if (sv.primary_enable && sv.vin_above_upper_uvlo) begin
          cur_next.state = st_reg_start;
        end
      end
      st_reg_start: begin
        // Bias waits for the regulator to clear its undervoltage level.
        if (sv.regulator_above_uvlo) begin
          cur_next.state = st_bias_charge;
        end
      end
      st_bias_charge: begin
        // Step-down starts only with the bias inside its window.
        if (sv.bias_in_window) begin
          cur_next.state = st_run;
        end
      end
      st_run: begin
        // Bias leaving its window drops every rail but regulator and bias, and reruns from step-down.
        if (!sv.bias_in_window) begin
          cur_next.state = st_bias_charge;
        end
      end
      st_thermal_hold: begin
        // Both causes must be gone before bias is enabled again.
        if (sv.temp_below_release && sv.vin_above_upper_uvlo) begin
          cur_next.state = st_bias_charge;
        end
      end
      st_fault: begin
        // Latch clears only once the regulator output has collapsed.
        if (!sv.regulator_above_uvlo) begin
          cur_next.state = st_reg_start;
        end
      end
    endcase

    // Over-temperature or brown-out keeps only the regulator.
    if ((cur_reg.state inside {st_reg_start, st_bias_charge, st_run}) &&
        (sv.temp_over_trip || !sv.vin_above_lower_uvlo)) begin
      cur_next.state = st_thermal_hold;
    end
    // A persistent armed fault shuts everything, regulator included.
    if ((cur_reg.state == st_run) && any_expired) begin
      cur_next.state = st_fault;
    end
    // Primary enable low wins over everything else.
    if (!sv.primary_enable) begin
      cur_next.state = st_off;
    end

    cur_next.fault_latch = (cur_next.state == st_fault);
    in_run = (cur_next.state == st_run);

    // Progress flags of the running sequence; all forgotten outside it.
    if (!in_run) begin
      cur_next.buck_reached = 1'b0;
      cur_next.neg_started = 1'b0;
      cur_next.switch_on = 1'b0;
      cur_next.pos_started = 1'b0;
    end else begin
      if (sv.buck_above_90) begin
        cur_next.buck_reached = 1'b1;
      end
      // Missing delay capacitor means the pump follows step-down at once.
      if (cur_reg.buck_reached && (sv.delay1_ramp_at_threshold || sv.delay1_cap_absent)) begin
        cur_next.neg_started = 1'b1;
      end
      // Secondary enable counts only after step-down is good.
      if (cur_reg.buck_reached && sv.secondary_enable) begin
        cur_next.switch_on = 1'b1;
      end
      // Positive pump restarts from scratch after secondary enable drops.
      if (!sv.secondary_enable) begin
        cur_next.pos_started = 1'b0;
      end else if (cur_reg.en.boost_en && sv.boost_above_90 &&
                   (sv.delay2_ramp_at_threshold || sv.delay2_cap_absent)) begin
        cur_next.pos_started = 1'b1;
      end
    end

    // Amplifier thermal flag tracks temperature with hysteresis.
    if (sv.temp_over_trip) begin
      cur_next.thermal_latch = 1'b1;
    end else if (sv.temp_below_release) begin
      cur_next.thermal_latch = 1'b0;
    end

    // Enables, registered so every output leaves a flip-flop.
    cur_next.en.regulator_en = cur_next.state inside
                               {st_reg_start, st_bias_charge, st_run, st_thermal_hold};
    cur_next.en.bias_en = cur_next.state inside {st_bias_charge, st_run};
    cur_next.en.buck_en = in_run;
    cur_next.en.delay1_ramp_en = in_run && cur_next.buck_reached;
    cur_next.en.neg_pump_en = in_run && cur_next.neg_started;
    cur_next.en.switch_en = in_run && cur_next.switch_on;
    // Step-up trails the switch by one cycle, so the switch is always first.
    cur_next.en.boost_en = in_run && sv.secondary_enable && cur_reg.switch_on;
    cur_next.en.delay2_ramp_en = cur_next.en.boost_en && sv.boost_above_90;
    cur_next.en.pos_pump_en = in_run && sv.secondary_enable && cur_next.pos_started;
    cur_next.en.gpm_en = cur_next.en.pos_pump_en && sv.slice_enable_input &&
                         sv.pos_above_90;
    cur_next.en.slice_mux_en = sv.slice_enable_input;
    cur_next.en.gate_high_ground = !sv.slice_enable_input;
    // Without primary enable the amplifiers never shut down for heat.
    cur_next.en.amp_shutdown = sv.primary_enable && cur_next.thermal_latch;
  end

  // State register; reset clears every field, so all outputs start low.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs straight from the state register.
  assign enables = cur_reg.en;
  assign fault_latch = cur_reg.fault_latch;
  assign osc_tick = cur_reg.osc_tick;
  assign pump_tick = cur_reg.pump_tick;

  property p_bias_after_regulator;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(enables.bias_en) && $past(cur_reg.state == st_reg_start) |->
        $past(sv.regulator_above_uvlo) && enables.regulator_en;
  endproperty
  a_bias_after_regulator: assert property (p_bias_after_regulator)
    else $error("Bias enabled before regulator was good.");

  property p_buck_needs_bias;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(enables.buck_en) |-> $past(sv.bias_in_window) && enables.bias_en;
  endproperty
  a_buck_needs_bias: assert property (p_buck_needs_bias)
    else $error("Step-down started with bias outside its window.");

  property p_bias_loss_drops;
    @(posedge ref_clk) disable iff (!reset_n)
      (cur_reg.state == st_run) && !sv.bias_in_window |=>
        !enables.buck_en && !enables.boost_en && !enables.neg_pump_en;
  endproperty
  a_bias_loss_drops: assert property (p_bias_loss_drops)
    else $error("Rails stayed on after bias left its window.");

  property p_switch_waits_buck;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(enables.switch_en) |-> $past(cur_reg.buck_reached && sv.secondary_enable);
  endproperty
  a_switch_waits_buck: assert property (p_switch_waits_buck)
    else $error("Inrush switch closed before step-down was good.");

  property p_primary_off;
    @(posedge ref_clk) disable iff (!reset_n)
      !sv.primary_enable |=> !enables.regulator_en && !enables.buck_en && !enables.switch_en;
  endproperty
  a_primary_off: assert property (p_primary_off)
    else $error("Functions stayed on after primary enable dropped.");

  property p_secondary_off;
    @(posedge ref_clk) disable iff (!reset_n)
      sv.primary_enable && !sv.secondary_enable |=>
        !enables.boost_en && !enables.pos_pump_en && !enables.gpm_en;
  endproperty
  a_secondary_off: assert property (p_secondary_off)
    else $error("Step-up side stayed on after secondary enable dropped.");

  property p_gpm_gate;
    @(posedge ref_clk) disable iff (!reset_n)
      enables.gpm_en |-> $past(sv.slice_enable_input && sv.pos_above_90);
  endproperty
  a_gpm_gate: assert property (p_gpm_gate)
    else $error("Modulator enabled without slice enable and good pump.");

  property p_fault_shutdown;
    @(posedge ref_clk) disable iff (!reset_n)
      (cur_reg.state == st_run) && any_expired && sv.primary_enable |=>
        fault_latch && !enables.regulator_en ##1 fault_latch;
  endproperty
  a_fault_shutdown: assert property (p_fault_shutdown)
    else $error("Persistent fault did not latch and shut down.");

  property p_pump_half_rate;
    @(posedge ref_clk) disable iff (!reset_n)
      pump_tick |-> osc_tick ##1 (!pump_tick)[*8];
  endproperty
  a_pump_half_rate: assert property (p_pump_half_rate)
    else $error("Pump tick not aligned to switching period.");

  property p_slice_ground;
    @(posedge ref_clk) disable iff (!reset_n)
      !sv.slice_enable_input |=> enables.gate_high_ground && !enables.slice_mux_en;
  endproperty
  a_slice_ground: assert property (p_slice_ground)
    else $error("Slice output not grounded with slice enable low.");

endmodule

/* File: verification/pss_rail_model.sv */
// Behavioural model of the rails, ramps and comparators around the sequencer.
`timescale 1ns/10ps

module pss_rail_model
  import pss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input pss_enables_t enables,
  input wire logic [8:0] ctl,
  output pss_sense_t sense
);
  // Control bits, high to low: slice output shorted, primary, secondary, slice,
  // rate, input good, hot, bias disturbed and step-down held low.
  // A shorted slice output never pulls up to the gate-high level.
  // Every rail answers its enable one edge later, like a very short soft start.
  // The ramps are modelled as past 2V as soon as their block runs, so fault
  // checking is always armed; this is the harshest case for the sequencer.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sense <= '0;
    end else begin
      // A held step-down output reads as below 90%, which is a fault.
      sense <= '{ctl[7], ctl[6], ctl[5], ctl[4], ctl[3], ctl[3], ctl[2], !ctl[2],
        enables.regulator_en, enables.bias_en & !ctl[1], enables.buck_en & !ctl[0],
        enables.buck_en, enables.delay1_ramp_en, 1'b0, enables.delay1_ramp_en, 1'b0, 1'b0,
        enables.boost_en, enables.boost_en, enables.delay2_ramp_en, 1'b0,
        enables.delay2_ramp_en, enables.pos_pump_en, enables.gpm_en & !ctl[8]};
    end
  end
endmodule

/* File: verification/tb_pss_sequencer.sv */
// Self-checking testbench for the panel supply sequencer.
`timescale 1ns/10ps

module tb_pss_sequencer
  import pss_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  // Pin and analog conditions that the bench steers.
  logic pe = 1'b0, se = 1'b0, sl = 1'b0, fq = 1'b0, vin = 1'b0, hot = 1'b0;
  logic bb = 1'b0, bf = 1'b0, gs = 1'b0;
  pss_sense_t sense;
  pss_enables_t enables;
  logic fault_latch, osc_tick, pump_tick;
  logic [12:0] ev;
  int err_count = 0;
  int n_checks = 0;

  // Flat view: bit 12 regulator down to bit 0 amplifier shutdown.
  assign ev = enables;

  // The 100 MHz reference clock.
  always #5 ref_clk = ~ref_clk;

  pss_sequencer u_pss_sequencer (
    .ref_clk(ref_clk), .reset_n(reset_n), .sense(sense), .enables(enables),
    .fault_latch(fault_latch), .osc_tick(osc_tick), .pump_tick(pump_tick));

  pss_rail_model u_pss_rail_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .enables(enables),
    .ctl({gs, pe, se, sl, fq, vin, hot, bb, bf}), .sense(sense));

  // Prints the counts and the verdict, then stops.
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Case-equal comparison of one bit.
  task chk(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Advances n edges; inputs then change 1 ns after the edge.
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Bounded wait for one enable bit to take a level.
  task wait_en(input int b, input logic v);
    for (int i = 0; i < 400 && ev[b] !== v; i++) cyc(1);
  endtask

  // Measures one switching period and the pump ticks over two periods.
  task tick_gap(input int exp);
    int n;
    int p;
    n = 0;
    p = 0;
    for (int i = 0; i < 400 && osc_tick !== 1'b1; i++) cyc(1);
    repeat (2) begin
      n = 0;
      do begin
        cyc(1);
        n++;
        p += int'(pump_tick === 1'b1);
      end while (osc_tick !== 1'b1 && n < 400);
    end
    chk("osc_period", 1'b1, n == exp);
    chk("pump_half_rate", 1'b1, p == 1);
  endtask

  // Cuts a hang short; the whole run needs about 26000 cycles.
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end

  // Main sequence of scenarios.
  initial begin
    cyc(10);
    reset_n = 1'b1;
    chk("off_after_reset", 1'b0, |ev);
    pe = 1'b1;
    cyc(50);
    chk("reg_en", 1'b0, ev[12]);
    // Secondary raised early while the step-down output is held low.
    se = 1'b1;
    bf = 1'b1;
    vin = 1'b1;
    wait_en(12, 1'b1);
    chk("reg_en", 1'b1, ev[12]);
    chk("bias_en", 1'b0, ev[11]);
    wait_en(10, 1'b1);
    chk("buck_en", 1'b1, ev[10]);
    cyc(20);
    chk("switch_en", 1'b0, ev[7]);
    chk("delay1_en", 1'b0, ev[9]);
    bf = 1'b0;
    wait_en(7, 1'b1);
    chk("boost_en", 1'b0, ev[6]);
    wait_en(6, 1'b1);
    chk("switch_en", 1'b1, ev[7]);
    wait_en(8, 1'b1);
    chk("delay1_en", 1'b1, ev[9]);
    chk("neg_pump_en", 1'b1, ev[8]);
    sl = 1'b1;
    wait_en(3, 1'b1);
    chk("pos_en", 1'b1, ev[4]);
    chk("delay2_en", 1'b1, ev[5]);
    // Slice input low parks the mux at ground.
    sl = 1'b0;
    cyc(6);
    chk("gpm_en", 1'b0, ev[3]);
    chk("slice_mux_en", 1'b0, ev[2]);
    chk("gate_high_ground", 1'b1, ev[1]);
    // Secondary enable dropped and restored.
    sl = 1'b1;
    se = 1'b0;
    cyc(6);
    chk("boost_en", 1'b0, ev[6]);
    chk("pos_en", 1'b0, ev[4]);
    chk("gpm_en", 1'b0, ev[3]);
    chk("buck_en", 1'b1, ev[10]);
    se = 1'b1;
    wait_en(4, 1'b1);
    chk("pos_en", 1'b1, ev[4]);
    // Over-temperature keeps only the regulator and stops the amplifiers.
    hot = 1'b1;
    cyc(6);
    chk("reg_en", 1'b1, ev[12]);
    chk("bias_en", 1'b0, ev[11]);
    chk("buck_en", 1'b0, ev[10]);
    chk("amp_shutdown", 1'b1, ev[0]);
    hot = 1'b0;
    wait_en(11, 1'b1);
    chk("bias_en", 1'b1, ev[11]);
    wait_en(3, 1'b1);
    chk("amp_shutdown", 1'b0, ev[0]);
    // Input brown-out acts like heat, but the amplifiers keep running.
    vin = 1'b0;
    cyc(6);
    chk("reg_en_brownout", 1'b1, ev[12]);
    chk("buck_en_brownout", 1'b0, ev[10]);
    chk("amp_brownout", 1'b0, ev[0]);
    vin = 1'b1;
    wait_en(3, 1'b1);
    chk("gpm_en_brownout", 1'b1, ev[3]);
    // Bias leaving its window drops the step-down until it recovers.
    bb = 1'b1;
    cyc(6);
    chk("buck_en", 1'b0, ev[10]);
    bb = 1'b0;
    wait_en(10, 1'b1);
    chk("buck_en", 1'b1, ev[10]);
    tick_gap(153);
    fq = 1'b1;
    cyc(10);
    tick_gap(76);
    // Fault broken off early, then held: 82 periods of 76 cycles at the high rate.
    wait_en(3, 1'b1);
    bf = 1'b1;
    cyc(70 * 76);
    bf = 1'b0;
    cyc(20);
    bf = 1'b1;
    cyc(80 * 76);
    chk("fault_latch_early", 1'b0, fault_latch);
    for (int i = 0; i < 600 && fault_latch !== 1'b1; i++) cyc(1);
    chk("fault_latch", 1'b1, fault_latch);
    chk("all_off_fault", 1'b0, |ev[12:3]);
    for (int i = 0; i < 50 && fault_latch !== 1'b0; i++) cyc(1);
    chk("fault_latch_clear", 1'b0, fault_latch);
    bf = 1'b0;
    wait_en(3, 1'b1);
    chk("gpm_en_restart", 1'b1, ev[3]);
    // A shorted slice output misses every pull-up; the fault latches and repeats.
    gs = 1'b1;
    cyc(60 * 76);
    chk("gpm_short_early", 1'b0, fault_latch);
    for (int i = 0; i < 2000 && fault_latch !== 1'b1; i++) cyc(1);
    chk("gpm_short_latch", 1'b1, fault_latch);
    for (int i = 0; i < 50 && fault_latch !== 1'b0; i++) cyc(1);
    for (int i = 0; i < 7000 && fault_latch !== 1'b1; i++) cyc(1);
    chk("gpm_short_relatch", 1'b1, fault_latch);
    gs = 1'b0;
    for (int i = 0; i < 50 && fault_latch !== 1'b0; i++) cyc(1);
    wait_en(3, 1'b1);
    chk("gpm_en_recovered", 1'b1, ev[3]);
    // Primary enable removed, then heat without primary enable.
    pe = 1'b0;
    cyc(6);
    chk("all_off_primary", 1'b0, |ev[12:3]);
    hot = 1'b1;
    cyc(6);
    chk("amp_shutdown", 1'b0, ev[0]);
    complete_run();
  end
endmodule
